// *** rtl/rpr_pkg.sv ***
// Shared constants for the resolver position readout link and both of its ends
//------------------------------------------------------------------------------
// How it works
// RULE_01: Select high reads position, low reads velocity
// RULE_02: Parallel lines driven only during chip-select read
// RULE_03: Read strobe fall copies selected word out
// RULE_04: Read strobe rise releases the parallel lines
// RULE_05: Sample fall latches position and velocity values
// RULE_06: Host honours sample width and read delay
// RULE_07: Serial mode: line eleven out, ten clock
// RULE_08: Serial mode loads sixteen-bit shifter on strobe
// RULE_09: Serial word MSB first, angle in top
// RULE_10: Bit three echoes the position/velocity choice
// RULE_11: Bits two, one carry fault flags
// RULE_12: Bit zero makes total ones count odd
// RULE_13: Position is unsigned binary fraction of turn
// RULE_14: Velocity is two's complement, MSB is direction
// RULE_15: MSB ready first fall, shift on rises
// RULE_16: Host drops strobe while serial clock high
// RULE_17: Extra serial clocks shift out zeros
// RULE_18: Host raises strobe after last falling edge
// RULE_19: Free-running 1024-line quadrature encoder emulation
// RULE_20: A leads B and direction high increasing
// RULE_21: North marker quarter A cycle at zero
// RULE_22: Four quadrature updates per pulse, paced internally
// RULE_23: Select high gives twelve-line parallel port
// RULE_24: Strobe or select release restarts serial frame
//------------------------------------------------------------------------------
package rpr_pkg;
   localparam int DATA_W = 12;
   localparam int WORD_W = 16;
   localparam int FIFO_DEPTH = 16;
   // Serial word layout
   localparam int BIT_SEL = 3;
   localparam int BIT_DEGRADE = 2;
   localparam int BIT_LOST = 1;
   localparam int BIT_PARITY = 0;
   // Data line roles in serial mode
   localparam int LINE_SO = 11;
   localparam int LINE_SCLK = 10;
   // Synchroniser bit positions of the device pin inputs
   localparam int SY_CS = 5;
   localparam int SY_RD = 4;
   localparam int SY_SAMPLE = 3;
   localparam int SY_SEL = 2;
   localparam int SY_SOE = 1;
   localparam int SY_SCLK = 0;
   localparam logic [5:0] SY_IDLE = 6'h3f;
   // Timing in nanoseconds and derived counts of sys_clk cycles
   localparam int CLK_NS = 40;
   localparam int XTAL_NS = 122;
   localparam int SAMPLE_NS = 2 * XTAL_NS + 20;
   localparam int SETTLE_NS = 6 * XTAL_NS + 20;
   localparam int GAP_NS = 18;
   localparam int UPDATE_NS = 244;
   localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int UPDATE_CYC = (UPDATE_NS / CLK_NS < 1) ? 1 : UPDATE_NS / CLK_NS;
   localparam int SCLK_HALF_CYC = 8;
   localparam int PAR_WAIT_CYC = 8;
   localparam logic [11:0] NORTH_POS = 12'h000;
endpackage

// *** rtl/rpr_if.sv ***
// Pin-level link between the converter readout and its host controller
`timescale 1ns/1ns
interface rpr_if;
   logic cs_n;
   logic rd_n;
   logic sample_n;
   logic pos_vel_select;
   logic serial_output_select;
   logic [11:0] dev_data_out;
   logic [11:0] dev_data_oe;
   logic host_sclk_out;
   logic host_sclk_oe;
   logic [11:0] data_line;
   logic enc_a;
   logic enc_b;
   logic direction_out;
   logic north_marker;

   // Resolve each shared line; an undriven line floats high via a pull-up
   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_line
         if (gi == rpr_pkg::LINE_SCLK) begin : g_sclk
            assign data_line[gi] = dev_data_oe[gi] ? dev_data_out[gi] :
                                   host_sclk_oe ? host_sclk_out : 1'b1;
         end else begin : g_plain
            assign data_line[gi] = dev_data_oe[gi] ? dev_data_out[gi] : 1'b1;
         end
      end
   endgenerate

   modport device (
      input cs_n,
      input rd_n,
      input sample_n,
      input pos_vel_select,
      input serial_output_select,
      input data_line,
      output dev_data_out,
      output dev_data_oe,
      output enc_a,
      output enc_b,
      output direction_out,
      output north_marker
   );

   modport host (
      output cs_n,
      output rd_n,
      output sample_n,
      output pos_vel_select,
      output serial_output_select,
      output host_sclk_out,
      output host_sclk_oe,
      input data_line,
      input enc_a,
      input enc_b,
      input direction_out,
      input north_marker
   );
endinterface

// *** rtl/rpr_fifo.sv ***
// Word FIFO with valid/ready on both sides
`timescale 1ns/1ns
module rpr_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   wire empty = (wr_ptr_reg == rd_ptr_reg);
   wire do_push = in_valid && !full && clk_en;
   wire do_pop = out_ready && !empty && clk_en;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem[rd_ptr_reg[AW-1:0]];

   // Storage is not reset; only the pointers carry meaning
   always_ff @(posedge sys_clk) begin
      if (do_push) begin
         mem[wr_ptr_reg[AW-1:0]] <= in_data;
      end
   end

   // Extra pointer bit tells full from empty
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule

// *** rtl/rpr_device.sv ***
// Converter end: parallel/serial readout of position and velocity, encoder emulation
`timescale 1ns/1ns
module rpr_device (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic [11:0] position_in,
   input wire logic [11:0] velocity_in,
   input wire logic signal_degradation_flag,
   input wire logic tracking_lost_flag,
   rpr_if.device link
);
   //---------------------------------------------------------------------------
   // Pin synchronisers
   //---------------------------------------------------------------------------
   logic [5:0] meta_reg;
   logic [5:0] sync_reg;
   logic [5:0] prev_reg;
   wire [5:0] pins = {link.cs_n, link.rd_n, link.sample_n, link.pos_vel_select,
                      link.serial_output_select, link.data_line[rpr_pkg::LINE_SCLK]};

   // Two flops per pin, a third only for edge detection
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= rpr_pkg::SY_IDLE;
         sync_reg <= rpr_pkg::SY_IDLE;
         prev_reg <= rpr_pkg::SY_IDLE;
      end else if (clk_en) begin
         meta_reg <= pins;
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
      end
   end

   // Decoded pin levels and edges
   wire cs_n_s = sync_reg[rpr_pkg::SY_CS];
   wire rd_n_s = sync_reg[rpr_pkg::SY_RD];
   wire sel_pos_s = sync_reg[rpr_pkg::SY_SEL];
   wire parallel_s = sync_reg[rpr_pkg::SY_SOE];
   wire rd_fall = prev_reg[rpr_pkg::SY_RD] && !rd_n_s && !cs_n_s;
   wire sample_fall = prev_reg[rpr_pkg::SY_SAMPLE] && !sync_reg[rpr_pkg::SY_SAMPLE];
   wire sclk_rise = !prev_reg[rpr_pkg::SY_SCLK] && sync_reg[rpr_pkg::SY_SCLK];
   wire reading = !cs_n_s && !rd_n_s;

   //---------------------------------------------------------------------------
   // Position and velocity registers
   //---------------------------------------------------------------------------
   logic [11:0] position_reg;
   logic [11:0] velocity_reg;

   // Integrators keep running; only the snapshot is frozen for reading
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         position_reg <= 12'h000;
         velocity_reg <= 12'h000;
      end else if (clk_en && sample_fall) begin
         position_reg <= position_in; // RULE_05 RULE_13
         velocity_reg <= velocity_in; // RULE_05 RULE_14
      end
   end

   //---------------------------------------------------------------------------
   // Output word assembly
   //---------------------------------------------------------------------------
   // Live select from the synchroniser
   wire [11:0] selected = sel_pos_s ? position_reg : velocity_reg; // RULE_01
   wire [15:1] word_body = {selected, sel_pos_s, signal_degradation_flag,
                            tracking_lost_flag}; // RULE_09 RULE_10 RULE_11
   wire parity = ~(^word_body); // RULE_12
   wire [15:0] serial_word = {word_body, parity};

   //---------------------------------------------------------------------------
   // Parallel buffer and serial shifter
   //---------------------------------------------------------------------------
   logic [11:0] out_buf_reg;
   logic [11:0] out_buf_next;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;

   // Buffer takes the selected word on each strobe fall
   assign out_buf_next = rd_fall ? selected : out_buf_reg; // RULE_03

   // Frame resets on release, loads on fall, shifts zeros in on rises
   always_comb begin
      shift_next = shift_reg;
      if (cs_n_s || rd_n_s) begin
         shift_next = 16'h0000; // RULE_24
      end else if (rd_fall) begin
         shift_next = serial_word; // RULE_08
      end else if (sclk_rise) begin
         shift_next = {shift_reg[14:0], 1'b0}; // RULE_15 RULE_17
      end
   end

   // Buffer keeps its word until the next strobe fall
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_buf_reg <= 12'h000;
      end else if (clk_en) begin
         out_buf_reg <= out_buf_next;
      end
   end

   // Cleared between frames so a stale bit never leaks out
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= 16'h0000;
      end else if (clk_en) begin
         shift_reg <= shift_next;
      end
   end

   //---------------------------------------------------------------------------
   // Data line drivers
   //---------------------------------------------------------------------------
   logic [11:0] data_out_reg;
   logic [11:0] data_oe_reg;
   // Serial mode drives only the serial output line; line ten is the host's clock
   wire [11:0] serial_lines = {shift_next[15], 11'h000};
   wire [11:0] serial_oe = 12'h800; // RULE_07
   wire [11:0] data_out_next = parallel_s ? out_buf_next : serial_lines; // RULE_23
   wire [11:0] data_oe_next = !reading ? 12'h000 : // RULE_02 RULE_04
                              parallel_s ? 12'hfff : serial_oe; // RULE_23 RULE_07

   // Driven from flops so the pins never glitch on decode changes
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_out_reg <= 12'h000;
      end else if (clk_en) begin
         data_out_reg <= data_out_next;
      end
   end

   // Enable trails the pin by three cycles
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_oe_reg <= 12'h000;
      end else if (clk_en) begin
         data_oe_reg <= data_oe_next;
      end
   end

   // Pins read the flops directly
   assign link.dev_data_out = data_out_reg;
   assign link.dev_data_oe = data_oe_reg;

   //---------------------------------------------------------------------------
   // Encoder emulation
   //---------------------------------------------------------------------------
   localparam logic [3:0] UPD_LAST = 4'(rpr_pkg::UPDATE_CYC - 1);
   logic [3:0] tick_cnt_reg;
   logic [11:0] enc_pos_reg;
   logic enc_a_reg;
   logic enc_b_reg;
   logic dir_reg;
   logic nm_reg;

   // Update pace stands in for the internal converter clock
   wire tick = (tick_cnt_reg == UPD_LAST); // RULE_22
   wire [11:0] diff = position_in - enc_pos_reg;
   wire moving = (diff != 12'h000);
   // Shortest way round: upper half of the difference means backwards
   wire step_up = !diff[11];
   wire [11:0] enc_pos_next = step_up ? enc_pos_reg + 12'h001 : enc_pos_reg - 12'h001;
   // Gray sequence on the two low bits, so A leads B counting up
   wire a_next = enc_pos_next[1] ^ enc_pos_next[0]; // RULE_20
   wire b_next = enc_pos_next[1];
   wire nm_next = (enc_pos_next == rpr_pkg::NORTH_POS); // RULE_21

   // Free-running update pace counter
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         tick_cnt_reg <= 4'h0;
      end else if (clk_en) begin
         tick_cnt_reg <= tick ? 4'h0 : tick_cnt_reg + 4'h1;
      end
   end

   // One count per update; four counts make one A cycle of 1024 per turn
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enc_pos_reg <= 12'h000;
         dir_reg <= 1'b1;
      end else if (clk_en && tick && moving) begin
         enc_pos_reg <= enc_pos_next; // RULE_19 RULE_22
         dir_reg <= step_up; // RULE_20
      end
   end

   // A, B and marker move on one edge
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         enc_a_reg <= 1'b0;
         enc_b_reg <= 1'b0;
         nm_reg <= 1'b1;
      end else if (clk_en && tick && moving) begin
         enc_a_reg <= a_next; // RULE_19 RULE_20
         enc_b_reg <= b_next; // RULE_19
         nm_reg <= nm_next; // RULE_21
      end
   end

   // Pins read the flops directly
   assign link.enc_a = enc_a_reg;
   assign link.enc_b = enc_b_reg;
   assign link.direction_out = dir_reg;
   assign link.north_marker = nm_reg;
endmodule

// *** rtl/rpr_host.sv ***
// Host controller end: samples, reads words over parallel or serial, queues them
`timescale 1ns/1ns
module rpr_host (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   input wire logic start,
   input wire logic start_select_pos,
   input wire logic start_serial,
   output logic busy,
   output logic word_valid,
   input wire logic word_ready,
   output logic [15:0] word_data,
   rpr_if.host link
);
   typedef enum logic [2:0] {H_IDLE, H_SAMPLE, H_SETTLE, H_PAR, H_SER, H_GAP} rpr_hstate_e;
   localparam logic [4:0] SAMPLE_LAST = 5'(rpr_pkg::SAMPLE_CYC - 1);
   localparam logic [4:0] SETTLE_LAST = 5'(rpr_pkg::SETTLE_CYC - 1);
   localparam logic [4:0] GAP_LAST = 5'(rpr_pkg::GAP_CYC - 1);
   localparam logic [4:0] HALF_LAST = 5'(rpr_pkg::SCLK_HALF_CYC - 1);
   localparam logic [4:0] PAR_LAST = 5'(rpr_pkg::PAR_WAIT_CYC - 1);

   rpr_hstate_e state_reg;
   logic [4:0] cnt_reg;
   logic [3:0] bit_cnt_reg;
   logic [11:0] meta_reg;
   logic [11:0] line_s_reg;
   logic [15:0] shift_in_reg;
   logic [15:0] word_reg;
   logic push_reg;
   logic sel_reg;
   logic ser_reg;
   logic cs_n_reg;
   logic rd_n_reg;
   logic sample_n_reg;
   logic sclk_reg;
   logic busy_reg;
   logic fifo_in_ready;

   // Data lines come from the device's domain
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_reg <= 12'h000;
         line_s_reg <= 12'h000;
      end else if (clk_en) begin
         meta_reg <= link.data_line;
         line_s_reg <= meta_reg;
      end
   end

   wire cnt_done_half = (cnt_reg == HALF_LAST);
   wire so_s = line_s_reg[rpr_pkg::LINE_SO];

   // Sequencer; a new read starts only when the queue has room
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= H_IDLE;
         cnt_reg <= 5'h00;
         bit_cnt_reg <= 4'h0;
         shift_in_reg <= 16'h0000;
         word_reg <= 16'h0000;
         push_reg <= 1'b0;
         sel_reg <= 1'b1;
         ser_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         rd_n_reg <= 1'b1;
         sample_n_reg <= 1'b1;
         sclk_reg <= 1'b1;
         busy_reg <= 1'b0;
      end else if (clk_en) begin
         push_reg <= 1'b0;
         cnt_reg <= cnt_reg + 5'h01;
         unique case (state_reg)
            H_IDLE: begin
               cnt_reg <= 5'h00;
               if (start && fifo_in_ready) begin
                  sel_reg <= start_select_pos; // RULE_01
                  ser_reg <= start_serial; // RULE_07 RULE_23
                  sample_n_reg <= 1'b0;
                  busy_reg <= 1'b1;
                  state_reg <= H_SAMPLE;
               end
            end
            H_SAMPLE: begin
               if (cnt_reg == SAMPLE_LAST) begin
                  sample_n_reg <= 1'b1; // RULE_06
                  cnt_reg <= 5'h00;
                  state_reg <= H_SETTLE;
               end
            end
            H_SETTLE: begin
               if (cnt_reg == SETTLE_LAST) begin
                  cs_n_reg <= 1'b0; // RULE_06
                  rd_n_reg <= 1'b0; // RULE_16
                  cnt_reg <= 5'h00;
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ser_reg ? H_SER : H_PAR;
               end
            end
            H_PAR: begin
               if (cnt_reg == PAR_LAST) begin
                  word_reg <= {line_s_reg, sel_reg, 3'h0};
                  push_reg <= 1'b1;
                  cs_n_reg <= 1'b1;
                  rd_n_reg <= 1'b1;
                  cnt_reg <= 5'h00;
                  state_reg <= H_GAP;
               end
            end
            H_SER: begin
               if (cnt_done_half) begin
                  cnt_reg <= 5'h00;
                  if (sclk_reg) begin
                     sclk_reg <= 1'b0;
                  end else begin
                     // Bit was put out on the last rise, the MSB on the strobe fall; take it just before the next rise
                     shift_in_reg <= {shift_in_reg[14:0], so_s};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     sclk_reg <= 1'b1;
                     if (bit_cnt_reg == 4'hf) begin
                        word_reg <= {shift_in_reg[14:0], so_s};
                        push_reg <= 1'b1;
                        cs_n_reg <= 1'b1; // RULE_18
                        rd_n_reg <= 1'b1; // RULE_18
                        state_reg <= H_GAP;
                     end
                  end
               end
            end
            H_GAP: begin
               if (cnt_reg == GAP_LAST) begin
                  busy_reg <= 1'b0;
                  state_reg <= H_IDLE;
               end
            end
         endcase
      end
   end

   assign link.cs_n = cs_n_reg;
   assign link.rd_n = rd_n_reg;
   assign link.sample_n = sample_n_reg;
   assign link.pos_vel_select = sel_reg;
   assign link.serial_output_select = !ser_reg;
   assign link.host_sclk_out = sclk_reg;
   assign link.host_sclk_oe = ser_reg;
   assign busy = busy_reg;

   // Queue of read words toward the user
   rpr_fifo #(
      .WIDTH(rpr_pkg::WORD_W),
      .DEPTH(rpr_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .in_valid(push_reg),
      .in_ready(fifo_in_ready),
      .in_data(word_reg),
      .out_valid(word_valid),
      .out_ready(word_ready),
      .out_data(word_data)
   );
endmodule

// *** test/rpr_checker.sv ***
// Concurrent checks on the pins between the converter end and the host end
`timescale 1ns/1ns
module rpr_checker (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic cs_n,
   input wire logic rd_n,
   input wire logic sample_n,
   input wire logic serial_output_select,
   input wire logic [11:0] dev_data_oe,
   input wire logic host_sclk_out,
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic direction_out,
   input wire logic north_marker
);
   //------------------------------------------------------------
   // Properties
   //------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Lines float once the strobe has been high past the synchroniser
   property p_oe_idle;
      rd_n [*4] |-> dev_data_oe == 12'h000;
   endproperty
   property p_oe_cause;
      $rose(dev_data_oe[11]) |-> $past(!rd_n, 3) && $past(!cs_n, 3);
   endproperty
   property p_par_lines;
      serial_output_select [*4] ##0 (dev_data_oe != 12'h000) |-> dev_data_oe == 12'hfff;
   endproperty
   // Only line eleven may drive in serial mode, line ten belongs to the host
   property p_ser_lines;
      !serial_output_select [*4] ##0 (dev_data_oe != 12'h000) |-> dev_data_oe == 12'h800;
   endproperty
   property p_sclk_high;
      $fell(rd_n) && !serial_output_select |-> host_sclk_out;
   endproperty
   property p_sample_width;
      $fell(sample_n) |=> !sample_n [*6];
   endproperty
   property p_quad_gray;
      $changed(enc_a) |-> $stable(enc_b);
   endproperty
   property p_quad_lead;
      $rose(enc_b) |-> enc_a == direction_out;
   endproperty
   property p_north;
      north_marker |-> !enc_a && !enc_b;
   endproperty
   // Steps are paced, never faster than one per update period
   property p_quad_pace;
      $changed({enc_a, enc_b}) |=> $stable({enc_a, enc_b}) [*5];
   endproperty
   //------------------------------------------------------------
   // Assertions and covers
   //------------------------------------------------------------
   a_oe_idle: assert property (p_oe_idle) else $error("lines driven while idle");
   a_oe_cause: assert property (p_oe_cause) else $error("drive without read");
   a_par_lines: assert property (p_par_lines) else $error("parallel oe wrong");
   a_ser_lines: assert property (p_ser_lines) else $error("serial oe wrong");
   a_sclk_high: assert property (p_sclk_high) else $error("strobe fell with clock low");
   a_sample_width: assert property (p_sample_width) else $error("sample too short");
   a_quad_gray: assert property (p_quad_gray) else $error("A and B moved together");
   a_quad_lead: assert property (p_quad_lead) else $error("A/B phase vs direction");
   a_north: assert property (p_north) else $error("marker outside zero state");
   a_quad_pace: assert property (p_quad_pace) else $error("encoder step too fast");
   c_ser: cover property (!serial_output_select && $rose(dev_data_oe[11]));
   c_par: cover property (serial_output_select && $rose(dev_data_oe[0]));
   c_north: cover property ($rose(north_marker));
endmodule

// *** test/resolver_position_readout_test.sv ***
// Self-checking bench joining converter end and host end over the pin link
`timescale 1ns/1ns
module resolver_position_readout_test;
   //------------------------------------------------------------
   // Stimulus, instances and checker
   //------------------------------------------------------------
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic start = 1'b0, sel_pos = 1'b0, ser = 1'b0, word_ready = 1'b0;
   logic degrade = 1'b0, lost = 1'b0, busy, word_valid;
   logic [11:0] position_in = 12'h000, velocity_in = 12'h000;
   logic [15:0] word_data;
   int failures = 0;
   int check_count = 0;
   // Free running system clock
   always #20 sys_clk = ~sys_clk;
   rpr_if link_if ();
   rpr_device rpr_device_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .position_in(position_in), .velocity_in(velocity_in),
      .signal_degradation_flag(degrade), .tracking_lost_flag(lost), .link(link_if));
   rpr_host rpr_host_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(1'b1),
      .start(start), .start_select_pos(sel_pos), .start_serial(ser), .busy(busy),
      .word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .link(link_if));
   rpr_checker rpr_checker_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cs_n(link_if.cs_n),
      .rd_n(link_if.rd_n), .sample_n(link_if.sample_n),
      .serial_output_select(link_if.serial_output_select), .dev_data_oe(link_if.dev_data_oe),
      .host_sclk_out(link_if.host_sclk_out), .enc_a(link_if.enc_a), .enc_b(link_if.enc_b),
      .direction_out(link_if.direction_out), .north_marker(link_if.north_marker));
   //------------------------------------------------------------
   // Shared tasks
   //------------------------------------------------------------
   task automatic finish_test();
      if (failures == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         failures++;
      end
   endtask
   // Bounded wait for idle host or a queued word, sampled mid-cycle
   task automatic wait_sig(input bit want_valid);
      for (int n = 0; n < 800; n++) begin
         @(negedge sys_clk);
         if (want_valid ? (word_valid === 1'b1) : (busy === 1'b0)) return;
      end
      failures++;
      finish_test();
   endtask
   function automatic logic [15:0] ser_word(input logic [11:0] d, input logic s,
         input logic g, input logic l);
      logic [15:0] w;
      w = {d, s, g, l, 1'b0};
      w[0] = ~^w[15:1];
      return w;
   endfunction
   task automatic pop_word(input logic [15:0] exp);
      wait_sig(1'b1);
      check("word_data", exp, word_data);
      @(posedge sys_clk);
      word_ready <= 1'b1;
      @(posedge sys_clk);
      word_ready <= 1'b0;
   endtask
   // Inputs flipped by chg mid-read, after the sample edge, must not leak
   task automatic read_word(input logic pos, input logic serial, input logic [11:0] chg,
         input logic [15:0] exp, input bit pop);
      wait_sig(1'b0);
      @(posedge sys_clk);
      start <= 1'b1;
      sel_pos <= pos;
      ser <= serial;
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (14) @(posedge sys_clk);
      position_in <= position_in ^ chg;
      velocity_in <= velocity_in ^ chg;
      if (pop) pop_word(exp);
   endtask
   //------------------------------------------------------------
   // Scenarios
   //------------------------------------------------------------
   task automatic t_encoder();
      int rises;
      logic last_a;
      for (int d = 0; d < 2; d++) begin
         @(posedge sys_clk);
         position_in <= d ? 12'h000 : 12'h010;
         rises = 0;
         last_a = link_if.enc_a;
         repeat (200) begin
            @(negedge sys_clk);
            if (link_if.enc_a === 1'b1 && last_a === 1'b0) rises++;
            last_a = link_if.enc_a;
         end
         check("enc_a rises", 16'h0004, 16'(rises));
         check("direction_out", 16'(1 - d), {15'h0000, link_if.direction_out});
         check("north_marker", 16'(d), {15'h0000, link_if.north_marker});
      end
   endtask
   // All four select and port combinations, back to back, boundary data
   task automatic t_modes();
      logic [11:0] d;
      for (int k = 0; k < 4; k++) begin
         d = k[0] ? 12'hfff : 12'h801;
         @(posedge sys_clk);
         position_in <= 12'hfff;
         velocity_in <= 12'h801;
         degrade <= k[1] ^ k[0];
         lost <= k[0];
         @(posedge sys_clk);
         read_word(k[0], k[1], 12'h000, k[1] ? ser_word(d, k[0], k[1] ^ k[0], k[0]) :
            {d, k[0], 3'h0}, 1'b1);
      end
   endtask
   task automatic t_latch();
      @(posedge sys_clk);
      position_in <= 12'h123;
      velocity_in <= 12'h456;
      read_word(1'b1, 1'b0, 12'h0ff, {12'h123, 1'b1, 3'h0}, 1'b1);
      read_word(1'b0, 1'b1, 12'h0ff, ser_word(12'h4a9, 1'b0, 1'b0, 1'b1), 1'b1);
   endtask
   // Fill the queue to refusal, then drain in order
   task automatic t_fifo();
      logic seen;
      for (int i = 0; i < 16; i++) begin
         @(posedge sys_clk);
         position_in <= 12'(i * 3 + 7);
         read_word(1'b1, 1'b0, 12'h000, 16'h0000, 1'b0);
      end
      wait_sig(1'b0);
      @(posedge sys_clk);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      seen = 1'b0;
      repeat (10) begin
         @(negedge sys_clk);
         if (busy !== 1'b0) seen = 1'b1;
      end
      check("busy when full", 16'h0000, {15'h0000, seen});
      for (int i = 0; i < 16; i++) begin
         pop_word({12'(i * 3 + 7), 1'b1, 3'h0});
      end
      @(negedge sys_clk);
      check("word_valid empty", 16'h0000, {15'h0000, word_valid});
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      t_encoder();
      t_modes();
      t_latch();
      t_fifo();
      finish_test();
   end
endmodule
